// File: epi_pkg.sv
// Package for the external pin interrupt unit: offsets, fields, resets, carriers
package epi_pkg;
   // Register byte addresses (no offsets printed, chosen locally)
   localparam logic [3:0] ADDR_SENSE_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_ENABLE_MASK = 4'h4;
   localparam logic [3:0] ADDR_PENDING_FLAGS = 4'h8;
   localparam logic [3:0] ADDR_GLOBAL_ENABLE = 4'hc;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
   localparam logic [1:0] ADDR_PAGE_CORE = 2'h0;
   localparam logic [1:0] ADDR_PAGE_SYS = 2'h1;

   // Field positions
   localparam int CH0_SENSE_LSB = 0;
   localparam int CH1_SENSE_LSB = 2;
   localparam int NUM_CH = 2;

   // Reset values
   localparam logic [3:0] RST_SENSE = 4'h0;
   localparam logic [1:0] RST_MASK = 2'h0;
   localparam logic [1:0] RST_FLAGS = 2'h0;
   localparam logic RST_GLOBAL = 1'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SENSE_LOW_LEVEL = 2'h0,
      SENSE_ANY_CHANGE = 2'h1,
      SENSE_FALLING = 2'h2,
      SENSE_RISING = 2'h3
   } epi_sense_e;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h0,
      WR_HAVE_ADDR = 2'h1,
      WR_RESP = 2'h3,
      WR_HAVE_DATA = 2'h2
   } epi_wr_state_e;

   typedef struct packed {
      logic [5:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [5:0] araddr;
      logic arvalid;
      logic rready;
   } epi_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } epi_axi_rsp_s;

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prev;
      logic prev_valid;
      logic [3:0] sense;
      logic [1:0] mask;
      logic [1:0] flags;
      logic global_en;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      epi_wr_state_e wr_state;
      logic [5:0] wr_addr;
      logic [31:0] wr_data;
      logic [3:0] wr_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } epi_state_s;
endpackage

// File: epi_unit.sv
// External pin interrupt unit: two sense-selectable pin channels behind AXI4-Lite
// Functional notes
// - Channel 1 sense field bits 3:2: low, any change, falling, rising.
// - Channel 0 sense field bits 1:0 uses the same four-way encoding.
// - Pins are sampled on the clock; edges found by comparing samples.
// - Edge or change pulses longer than one clock always raise a request.
// - A channel reaches the core only with global and channel enables set; wake_req ignores global enable, irq ignores both.
// - Unused sense bits 7:4 and mask/flag bits 7:2 read zero.
// - Enable mask: bit 1 channel 1, bit 0 channel 0, read/write, reset 0.
// - Pin activity raises requests even when the pin is an output.
// - A triggering edge or change sets that channel's pending flag.
// - Flag set with both enables set signals the core for that channel.
// - Core acknowledge of a channel's routine clears its flag.
// - Writing one to a flag clears it; writing zero leaves it.
// - In low-level sense the flag reads zero; pin level drives the request.
// - Each channel has its own request output toward the core.
// - Edge detection needs the clock; no clock means no edge requests.
// - Low-level detection works without a clock for wake-up.
`timescale 1ns/1ps
`default_nettype none
module epi_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic [1:0] core_ack,
   input wire epi_pkg::epi_axi_req_s axi_req,
   output epi_pkg::epi_axi_rsp_s axi_rsp,
   output logic [1:0] core_irq_req,
   output logic [1:0] wake_req,
   output logic irq
);
   epi_pkg::epi_state_s s;
   epi_pkg::epi_state_s next_s;
   logic [1:0] pins;
   logic [1:0] trig;
   logic [1:0] low_mode;
   logic [1:0] flag_view;
   logic wr_fire;
   logic rd_fire;
   logic [5:0] rd_addr;
   logic wr_hit;

   assign pins = {ext_irq_pin_1, ext_irq_pin_0};

   // Per-channel trigger detection
   for (genvar ch = 0; ch < epi_pkg::NUM_CH; ch++) begin : g_ch
      epi_pkg::epi_sense_e mode;
      logic cur;
      logic old;
      assign mode = epi_pkg::epi_sense_e'(s.sense[2 * ch +: 2]);
      assign cur = s.sync2[ch];
      assign old = s.prev[ch];
      assign low_mode[ch] = (mode == epi_pkg::SENSE_LOW_LEVEL);
      always_comb begin
         // Samples only advance on clock edges, so edges need the clock
         trig[ch] = 1'b0;
         if (s.prev_valid) begin
            unique case (mode)
               epi_pkg::SENSE_LOW_LEVEL: trig[ch] = 1'b0;
               epi_pkg::SENSE_ANY_CHANGE: trig[ch] = cur ^ old;
               epi_pkg::SENSE_FALLING: trig[ch] = old & ~cur;
               epi_pkg::SENSE_RISING: trig[ch] = ~old & cur;
            endcase
         end
      end
      // Flag hidden in low-level mode; raw pin drives the request there
      assign flag_view[ch] = low_mode[ch] ? 1'b0 : s.flags[ch];
      assign core_irq_req[ch] = s.global_en & s.mask[ch] &
         (low_mode[ch] ? ~pins[ch] : s.flags[ch]);
      // Combinational from the pin so it works while the clock is stopped
      assign wake_req[ch] = s.mask[ch] & low_mode[ch] & ~pins[ch];
   end

   assign wr_fire = (s.wr_state == epi_pkg::WR_RESP) && !s.bvalid;
   assign rd_fire = axi_req.arvalid && !s.rvalid;
   assign rd_addr = axi_req.araddr;
   assign wr_hit = wr_fire && (s.wr_strb[0] == 1'b1);

   always_comb begin
      next_s = s;
      // Pins feed the synchroniser regardless of pin direction
      next_s.sync1 = pins;
      next_s.sync2 = s.sync1;
      next_s.prev = s.sync2;
      next_s.prev_valid = 1'b1;

      // Write channel: take address and data in either order
      unique case (s.wr_state)
         epi_pkg::WR_IDLE: begin
            if (axi_req.awvalid && axi_req.wvalid) begin
               next_s.wr_addr = axi_req.awaddr;
               next_s.wr_data = axi_req.wdata;
               next_s.wr_strb = axi_req.wstrb;
               next_s.wr_state = epi_pkg::WR_RESP;
            end else if (axi_req.awvalid) begin
               next_s.wr_addr = axi_req.awaddr;
               next_s.wr_state = epi_pkg::WR_HAVE_ADDR;
            end else if (axi_req.wvalid) begin
               next_s.wr_data = axi_req.wdata;
               next_s.wr_strb = axi_req.wstrb;
               next_s.wr_state = epi_pkg::WR_HAVE_DATA;
            end
         end
         epi_pkg::WR_HAVE_ADDR: begin
            if (axi_req.wvalid) begin
               next_s.wr_data = axi_req.wdata;
               next_s.wr_strb = axi_req.wstrb;
               next_s.wr_state = epi_pkg::WR_RESP;
            end
         end
         epi_pkg::WR_HAVE_DATA: begin
            if (axi_req.awvalid) begin
               next_s.wr_addr = axi_req.awaddr;
               next_s.wr_state = epi_pkg::WR_RESP;
            end
         end
         epi_pkg::WR_RESP: begin
            if (s.bvalid && axi_req.bready) begin
               next_s.bvalid = 1'b0;
               next_s.wr_state = epi_pkg::WR_IDLE;
            end
         end
      endcase

      // Flag clears first; new triggers below win over them
      next_s.flags = s.flags & ~core_ack;
      if (wr_fire) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = epi_pkg::RESP_OKAY;
         if (s.wr_addr[5:4] == epi_pkg::ADDR_PAGE_CORE) begin
            unique case (s.wr_addr[3:0])
               epi_pkg::ADDR_SENSE_CONTROL:
                  if (wr_hit) next_s.sense = s.wr_data[3:0];
               epi_pkg::ADDR_ENABLE_MASK:
                  if (wr_hit) next_s.mask = s.wr_data[1:0];
               epi_pkg::ADDR_PENDING_FLAGS:
                  if (wr_hit) next_s.flags = next_s.flags & ~s.wr_data[1:0];
               epi_pkg::ADDR_GLOBAL_ENABLE:
                  if (wr_hit) next_s.global_en = s.wr_data[0];
               default: next_s.bresp = epi_pkg::RESP_SLVERR;
            endcase
         end else if (s.wr_addr[5:4] == epi_pkg::ADDR_PAGE_SYS &&
                      s.wr_addr[3:0] == epi_pkg::ADDR_IRQ_MASK) begin
            if (wr_hit) next_s.irq_mask = s.wr_data[1:0];
         end else if (s.wr_addr[5:4] == epi_pkg::ADDR_PAGE_SYS &&
                      s.wr_addr[3:0] == epi_pkg::ADDR_IRQ_STATUS) begin
            next_s.bresp = epi_pkg::RESP_OKAY;
         end else begin
            next_s.bresp = epi_pkg::RESP_SLVERR;
         end
      end
      // Low-level channels keep their flag clear
      next_s.flags = (next_s.flags | trig) & ~low_mode;

      // Read channel; status read clears its sticky bits
      if (s.rvalid && axi_req.rready) begin
         next_s.rvalid = 1'b0;
      end
      if (rd_fire) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = epi_pkg::RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         if (rd_addr[5:4] == epi_pkg::ADDR_PAGE_CORE) begin
            unique case (rd_addr[3:0])
               epi_pkg::ADDR_SENSE_CONTROL: next_s.rdata[3:0] = s.sense;
               epi_pkg::ADDR_ENABLE_MASK: next_s.rdata[1:0] = s.mask;
               epi_pkg::ADDR_PENDING_FLAGS: next_s.rdata[1:0] = flag_view;
               epi_pkg::ADDR_GLOBAL_ENABLE: next_s.rdata[0] = s.global_en;
               default: next_s.rresp = epi_pkg::RESP_SLVERR;
            endcase
         end else if (rd_addr[5:4] == epi_pkg::ADDR_PAGE_SYS &&
                      rd_addr[3:0] == epi_pkg::ADDR_IRQ_STATUS) begin
            next_s.rdata[1:0] = s.irq_status;
            next_s.irq_status = 2'h0;
         end else if (rd_addr[5:4] == epi_pkg::ADDR_PAGE_SYS &&
                      rd_addr[3:0] == epi_pkg::ADDR_IRQ_MASK) begin
            next_s.rdata[1:0] = s.irq_mask;
         end else begin
            next_s.rresp = epi_pkg::RESP_SLVERR;
         end
      end
      // Set wins over the read clear
      next_s.irq_status = next_s.irq_status | trig;

      if (rst) begin
         next_s = '0;
         // Seed every sample stage from the pin so release shows no false edge
         next_s.sync1 = pins;
         next_s.sync2 = pins;
         next_s.prev = pins;
         next_s.sense = epi_pkg::RST_SENSE;
         next_s.mask = epi_pkg::RST_MASK;
         next_s.flags = epi_pkg::RST_FLAGS;
         next_s.global_en = epi_pkg::RST_GLOBAL;
         next_s.wr_state = epi_pkg::WR_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   always_comb begin
      axi_rsp.awready = (s.wr_state == epi_pkg::WR_IDLE) ||
                        (s.wr_state == epi_pkg::WR_HAVE_DATA);
      axi_rsp.wready = (s.wr_state == epi_pkg::WR_IDLE) ||
                       (s.wr_state == epi_pkg::WR_HAVE_ADDR);
      axi_rsp.bvalid = s.bvalid;
      axi_rsp.bresp = s.bresp;
      axi_rsp.arready = !s.rvalid;
      axi_rsp.rvalid = s.rvalid;
      axi_rsp.rdata = s.rdata;
      axi_rsp.rresp = s.rresp;
   end

   assign irq = |(s.irq_status & s.irq_mask);
endmodule
`default_nettype wire

// File: epi_unit_sva.sv
// Port-level assertion checker for the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epi_unit_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic [1:0] core_ack,
   input wire epi_pkg::epi_axi_req_s axi_req,
   input wire epi_pkg::epi_axi_rsp_s axi_rsp,
   input wire logic [1:0] core_irq_req,
   input wire logic [1:0] wake_req,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_wr_answer;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_wr_block;
      axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write taken while answer pending");
   property p_b_hold;
      axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_answer;
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_ar_ready;
      axi_rsp.arready == !axi_rsp.rvalid;
   endproperty
   a_ar_ready: assert property (p_ar_ready) else $error("read ready wrong");
   property p_r_hold;
      axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_slverr;
      axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 6'h18
         |=> axi_rsp.rresp == epi_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
   property p_wake;
      (wake_req & {ext_irq_pin_1, ext_irq_pin_0}) == 2'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("wake with pin high");
endmodule
bind epi_unit epi_unit_chk u_chk (.clk(clk), .rst(rst), .ext_irq_pin_0(ext_irq_pin_0),
   .ext_irq_pin_1(ext_irq_pin_1), .core_ack(core_ack), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .core_irq_req(core_irq_req), .wake_req(wake_req), .irq(irq));
`default_nettype wire

// File: epi_pin_src.sv
// Pin source model: held levels plus two-cycle inverted pulses
`timescale 1ns/1ps
`default_nettype none
module epi_pin_src (
   input wire logic clk,
   input wire logic [1:0] lvl,
   input wire logic [1:0] pulse,
   output logic [1:0] pin
);
   logic [1:0] p_a = 2'h0;
   logic [1:0] p_b = 2'h0;
   always_ff @(posedge clk) begin
      p_a <= pulse;
      p_b <= p_a;
   end
   // Pulses last two clocks so edge capture is guaranteed
   assign pin = lvl ^ (p_a | p_b);
endmodule
`default_nettype wire

// File: external_pin_interrupt_unit_bench.sv
// Self-checking bench for the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit_bench;
   logic clk = 0;
   logic rst = 1;
   logic [1:0] lvl = 2'h3, pls = 2'h0, ack = 2'h0, pin, req, wake, r;
   logic irq;
   logic [31:0] d;
   epi_pkg::epi_axi_req_s q;
   epi_pkg::epi_axi_rsp_s s;
   int fails = 0, checks = 0;
   always #12.5 clk = ~clk;
   epi_pin_src u_src (.clk(clk), .lvl(lvl), .pulse(pls), .pin(pin));
   epi_unit u_dut (.clk(clk), .rst(rst), .ext_irq_pin_0(pin[0]), .ext_irq_pin_1(pin[1]),
      .core_ack(ack), .axi_req(q), .axi_rsp(s), .core_irq_req(req), .wake_req(wake), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1;
      w = 1;
      q.awaddr <= a;
      q.wdata <= v;
      q.awvalid <= 1;
      q.wvalid <= 1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && s.awready === 1'b1) begin
            aw = 0;
            q.awvalid <= 0;
         end
         if (w && s.wready === 1'b1) begin
            w = 0;
            q.wvalid <= 0;
         end
      end
      do @(posedge clk); while (s.bvalid !== 1'b1);
      r = s.bresp;
   endtask
   task automatic rd(input logic [5:0] a);
      q.araddr <= a;
      q.arvalid <= 1;
      do @(posedge clk); while (s.arready !== 1'b1);
      q.arvalid <= 0;
      do @(posedge clk); while (s.rvalid !== 1'b1);
      d = s.rdata;
      r = s.rresp;
   endtask
   task automatic t_regs;
      rd(6'h00); chk(d, 32'h0);
      rd(6'h04); chk(d, 32'h0);
      wr(6'h00, '1); chk({30'h0, r}, {30'h0, epi_pkg::RESP_OKAY});
      rd(6'h00); chk(d, 32'hf);
      wr(6'h1c, 32'h0); chk({30'h0, r}, {30'h0, epi_pkg::RESP_SLVERR});
      wr(6'h04, '1); rd(6'h04); chk(d, 32'h3);
      rd(6'h18); chk({30'h0, r}, {30'h0, epi_pkg::RESP_SLVERR});
   endtask
   task automatic t_modes;
      int f, g;
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            f = (k == 1 || k == 2);
            g = (k == 1 || k == 3);
            wr(6'h00, 32'(k) << (2 * c));
            wr(6'h08, 32'h3);
            lvl[c] <= 1'b0;
            go(6);
            rd(6'h08); chk(d, 32'(f) << c);
            chk({30'h0, req}, 32'(k != 3) << c);
            chk({30'h0, wake}, 32'(k == 0) << c);
            wr(6'h08, 32'h3);
            lvl[c] <= 1'b1;
            go(6);
            rd(6'h08); chk(d, 32'(g) << c);
            chk({30'h0, req}, 32'(g) << c);
         end
      end
   endtask
   task automatic t_gate;
      wr(6'h00, 32'hf);
      wr(6'h08, 32'h3);
      pls <= 2'h1;
      go(1);
      pls <= 2'h0;
      go(8);
      rd(6'h08); chk(d, 32'h1);
      wr(6'h08, 32'h0); rd(6'h08); chk(d, 32'h1);
      wr(6'h0c, 32'h0); go(1); chk({30'h0, req}, 32'h0);
      wr(6'h0c, 32'h1); go(1); chk({30'h0, req}, 32'h1);
      wr(6'h04, 32'h2); go(1); chk({30'h0, req}, 32'h0);
      wr(6'h04, 32'h3);
      ack <= 2'h1;
      go(1);
      ack <= 2'h0;
      go(1);
      rd(6'h08); chk(d, 32'h0);
   endtask
   task automatic t_irq;
      rd(6'h10);
      wr(6'h14, 32'h0);
      pls <= 2'h2;
      go(1);
      pls <= 2'h0;
      go(8);
      chk({31'h0, irq}, 32'h0);
      wr(6'h14, 32'h2); go(1); chk({31'h0, irq}, 32'h1);
      rd(6'h10); chk(d, 32'h2);
      go(1); chk({31'h0, irq}, 32'h0);
   endtask
   task automatic give_verdict;
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      q = '0;
      q.wstrb = 4'hf;
      // Always ready for answers, so no strobe is toggled twice in a step
      q.bready = 1;
      q.rready = 1;
      go(6);
      rst <= 0;
      t_regs();
      wr(6'h0c, 32'h1);
      t_modes();
      t_gate();
      t_irq();
      give_verdict();
   end
   initial begin
      #(25 * 20000);
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
